// ==== rtl/sccpm_params.svh ====
// register offsets, field positions, reset values and counts for the idle clock control.
// assumes a byte-addressed 8-bit register port with 32-bit data.
//
// Contract
// - access flag reads 1 once the card was accessed since last clear
// - reading the power management register clears the access flag; resets to 0
// - read-only rate-changed bit: 1 while the card clock is stopped or slowed
// - stop/slow selection applies only while the enable bit is 1; reset 0
// - enabled with select 0: clock-run logic may attempt to stop the clock
// - enabled with select 1: clock-run logic may attempt to slow the clock by 16
// - stop or slow only while the socket is idle, never during card use
// - reserved bits of the power management register read 0, writes ignored
// - attempt only after eight consecutive idle card clock cycles
// - policy 0 also needs host clock-run stop request; policy 1 idle alone suffices
`ifndef SCCPM_PARAMS_SVH
`define SCCPM_PARAMS_SVH
`define SCCPM_OFS_SKT_CTL 8'h10
`define SCCPM_OFS_PM 8'h20
`define SCCPM_OFS_IRQ_STAT 8'h24
`define SCCPM_OFS_IRQ_CLR 8'h28
`define SCCPM_OFS_IRQ_EN 8'h2C
`define SCCPM_BIT_ACCESS 25
`define SCCPM_BIT_RATE 24
`define SCCPM_BIT_ENABLE 16
`define SCCPM_BIT_SLOW 0
`define SCCPM_BIT_POLICY 7
`define SCCPM_RESET_PM 32'h0000_0000
`define SCCPM_IDLE_CLKS 8
`define SCCPM_SLOW_DIV 16
`define SCCPM_IRQ_ACCESS 0
`define SCCPM_IRQ_CHANGE 1
`define SCCPM_IRQ_RESTORE 2
`endif

// ==== rtl/sccpm_pkg.sv ====
// types shared by the idle clock control block.
// assumes sccpm_params.svh holds the numeric constants.
package sccpm_pkg;
  typedef struct packed {
    logic enable;
    logic slow_sel;
    logic stop_policy;
  } sccpm_ctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sccpm_bus_t;

  typedef enum logic [2:0] {
    SCCPM_RUN = 3'b001,
    SCCPM_STOP = 3'b010,
    SCCPM_SLOW = 3'b100
  } sccpm_state_t;
endpackage : sccpm_pkg

// ==== rtl/sccpm_idle_clock_ctl.sv ====
// per-socket idle clock control: stop or slow the card clock after idle time.
// assumes a register master on i_sys_clk and raw card-side pins from another domain.
`timescale 1ns/10ps
`include "sccpm_params.svh"

module sccpm_idle_clock_ctl
  import sccpm_pkg::*;
#(
  parameter int IDLE_CLKS = `SCCPM_IDLE_CLKS
) (
  input wire logic i_sys_clk, // 40 MHz system clock
  input wire logic i_reset, // synchronous, active high
  input wire logic [7:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after i_rd
  input wire logic i_card_clk, // card bus clock pin, sampled
  input wire logic i_card_busy, // socket in use (card access active), pin
  input wire logic i_host_stop_req, // host clock-run preparing to stop
  output logic o_clk_stop_req, // request card clock stop
  output logic o_clk_slow_req, // request card clock slow by 16
  output logic o_irq // level interrupt
);

  // one carrier for the register port keeps the decode below in one place
  sccpm_bus_t bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // two-flop synchronisers; stage 1 is read only by stage 2
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic clk_prev_q;
  logic busy_prev_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      clk_prev_q <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      sync1_q <= {i_host_stop_req, i_card_busy, i_card_clk};
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[0];
      busy_prev_q <= sync2_q[1];
    end
  end

  wire card_clk_s = sync2_q[0];
  wire busy_s = sync2_q[1];
  wire host_stop_s = sync2_q[2];
  wire card_edge = card_clk_s & ~clk_prev_q;
  wire access_evt = busy_s & ~busy_prev_q;

  // register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  wire wr_pm = bus.wr & hit(bus.addr, `SCCPM_OFS_PM);
  wire wr_skt = bus.wr & hit(bus.addr, `SCCPM_OFS_SKT_CTL);
  wire wr_clr = bus.wr & hit(bus.addr, `SCCPM_OFS_IRQ_CLR);
  wire wr_en = bus.wr & hit(bus.addr, `SCCPM_OFS_IRQ_EN);
  wire rd_pm = bus.rd & hit(bus.addr, `SCCPM_OFS_PM);
  wire rd_skt = bus.rd & hit(bus.addr, `SCCPM_OFS_SKT_CTL);
  wire rd_mapped = rd_pm | rd_skt | (bus.rd & hit(bus.addr, `SCCPM_OFS_IRQ_STAT))
                   | (bus.rd & hit(bus.addr, `SCCPM_OFS_IRQ_EN));

  // only the defined control bits are kept; the rest of a write is dropped
  sccpm_ctl_t ctl_q;
  sccpm_ctl_t ctl_d;
  always_comb begin
    ctl_d = ctl_q;
    if (wr_pm) begin
      ctl_d.enable = bus.wdata[`SCCPM_BIT_ENABLE];
      ctl_d.slow_sel = bus.wdata[`SCCPM_BIT_SLOW];
    end
    if (wr_skt) begin
      ctl_d.stop_policy = bus.wdata[`SCCPM_BIT_POLICY];
    end
  end

  // access flag: a new access in the clearing read cycle wins
  logic access_q;
  wire access_d = access_evt | (access_q & ~rd_pm);

  // idle counter, advanced on card clock edges while the socket is quiet
  // it saturates, so a long idle span cannot wrap and restart the wait
  localparam int CW = $clog2(IDLE_CLKS + 1);
  localparam logic [CW-1:0] IDLE_MAX = CW'(IDLE_CLKS);
  logic [CW-1:0] idle_cnt_q;
  logic [CW-1:0] idle_cnt_d;
  always_comb begin
    idle_cnt_d = idle_cnt_q;
    if (busy_s) begin
      idle_cnt_d = '0;
    end else if (card_edge && idle_cnt_q != IDLE_MAX) begin
      idle_cnt_d = idle_cnt_q + CW'(1);
    end
  end

  wire idle_done = (idle_cnt_q == IDLE_MAX) & ~busy_s;
  wire policy_ok = ctl_q.stop_policy | host_stop_s;
  wire may_attempt = ctl_q.enable & idle_done & policy_ok;

  // an attempt only starts from full rate; stop and slow never hand over directly
  sccpm_state_t state_q;
  sccpm_state_t state_d;
  always_comb begin
    case (state_q)
      SCCPM_RUN: begin
        if (may_attempt) begin
          state_d = ctl_q.slow_sel ? SCCPM_SLOW : SCCPM_STOP;
        end else begin
          state_d = SCCPM_RUN;
        end
      end
      SCCPM_STOP, SCCPM_SLOW: begin
        // any card use or loss of enable restores full rate at once
        if (busy_s || !ctl_q.enable) begin
          state_d = SCCPM_RUN;
        end else begin
          state_d = state_q;
        end
      end
      default: state_d = SCCPM_RUN;
    endcase
  end

  wire enter_evt = (state_q == SCCPM_RUN) & (state_d != SCCPM_RUN);
  wire leave_evt = (state_q != SCCPM_RUN) & (state_d == SCCPM_RUN);
  // no card acknowledge is awaited, so the rate bit follows our own request;
  // the cost is that a card slow to react is reported as changed early
  logic rate_changed_q;

  // interrupt status, set wins over write-one clear
  logic [2:0] irq_stat_q;
  logic [2:0] irq_en_q;
  wire [2:0] irq_set = {leave_evt, enter_evt, access_evt};
  wire [2:0] irq_stat_d = irq_set | (irq_stat_q & ~(wr_clr ? bus.wdata[2:0] : 3'h0));
  wire [2:0] irq_en_d = wr_en ? bus.wdata[2:0] : irq_en_q;

  // read mux; reserved bits and unmapped addresses read zero
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `SCCPM_OFS_PM: begin
          rdata_d[`SCCPM_BIT_ACCESS] = access_q;
          rdata_d[`SCCPM_BIT_RATE] = rate_changed_q;
          rdata_d[`SCCPM_BIT_ENABLE] = ctl_q.enable;
          rdata_d[`SCCPM_BIT_SLOW] = ctl_q.slow_sel;
        end
        `SCCPM_OFS_SKT_CTL: rdata_d[`SCCPM_BIT_POLICY] = ctl_q.stop_policy;
        `SCCPM_OFS_IRQ_STAT: rdata_d[2:0] = irq_stat_q;
        `SCCPM_OFS_IRQ_EN: rdata_d[2:0] = irq_en_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctl_q <= '0;
      access_q <= 1'b0;
      idle_cnt_q <= '0;
      state_q <= SCCPM_RUN;
      rate_changed_q <= 1'b0;
      irq_stat_q <= 3'h0;
      irq_en_q <= 3'h0;
      o_rdata <= 32'h0000_0000;
      o_clk_stop_req <= 1'b0;
      o_clk_slow_req <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      access_q <= access_d;
      idle_cnt_q <= idle_cnt_d;
      state_q <= state_d;
      rate_changed_q <= state_d != SCCPM_RUN;
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      o_rdata <= rdata_d;
      o_clk_stop_req <= state_d == SCCPM_STOP;
      o_clk_slow_req <= state_d == SCCPM_SLOW;
      o_irq <= |(irq_stat_d & irq_en_d);
    end
  end

  // checks; they judge the synchronised pins, not the raw ones
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  access_set_a: assert property (access_evt |=> access_q)
    else $error("access flag not set after card access");
  access_clear_a: assert property (rd_pm && !access_evt |=> !access_q)
    else $error("access flag not cleared by register read");
  rate_bit_a: assert property (rate_changed_q == (o_clk_stop_req | o_clk_slow_req))
    else $error("rate bit disagrees with clock request");
  enable_gate_a: assert property (!ctl_q.enable |=> !o_clk_stop_req && !o_clk_slow_req)
    else $error("clock request while control disabled");
  stop_sel_a: assert property ($rose(o_clk_stop_req) |-> $past(!ctl_q.slow_sel))
    else $error("stop requested with slow selected");
  slow_sel_a: assert property ($rose(o_clk_slow_req) |-> $past(ctl_q.slow_sel))
    else $error("slow requested with stop selected");
  busy_release_a: assert property (busy_s |=> !o_clk_stop_req && !o_clk_slow_req)
    else $error("clock request while socket busy");
  reserved_zero_a: assert property (rd_pm |=> (o_rdata & 32'hFCFE_FFFE) == 32'h0)
    else $error("reserved bits read nonzero");
  idle_count_a: assert property (state_q == SCCPM_RUN && state_d != SCCPM_RUN
                                 |-> idle_cnt_q == IDLE_MAX)
    else $error("attempt before idle count reached");
  policy_host_a: assert property (enter_evt |-> ctl_q.stop_policy || host_stop_s)
    else $error("attempt without host stop under policy 0");
  restore_clr_a: assert property (leave_evt |=> !rate_changed_q)
    else $error("rate bit stays set after restore");
  disable_run_a: assert property (!ctl_q.enable && state_q != SCCPM_RUN
                                  |=> state_q == SCCPM_RUN)
    else $error("clock not restored after disable");

  // access flag: held until a read, a new access wins over the clearing read
  access_hold_a: assert property (access_q && !rd_pm |=> access_q)
    else $error("access flag lost without a read");

  access_quiet_a: assert property (!access_q && !access_evt |=> !access_q)
    else $error("access flag set without card access");

  access_race_a: assert property (rd_pm && access_evt |=> access_q)
    else $error("new access lost in clearing read");

  access_read_a: assert property (rd_pm
                                  |=> o_rdata[`SCCPM_BIT_ACCESS] == $past(access_q))
    else $error("access flag read back wrong");

  // control register fields
  enable_write_a: assert property (wr_pm
                                   |=> ctl_q.enable == $past(bus.wdata[`SCCPM_BIT_ENABLE]))
    else $error("enable bit not written");

  slow_write_a: assert property (wr_pm
                                 |=> ctl_q.slow_sel == $past(bus.wdata[`SCCPM_BIT_SLOW]))
    else $error("select bit not written");

  policy_write_a: assert property (wr_skt
                                   |=> ctl_q.stop_policy == $past(bus.wdata[`SCCPM_BIT_POLICY]))
    else $error("policy bit not written");

  ctl_hold_a: assert property (!wr_pm && !wr_skt |=> $stable(ctl_q))
    else $error("control bits changed without a write");

  enable_read_a: assert property (rd_pm
                                  |=> o_rdata[`SCCPM_BIT_ENABLE] == $past(ctl_q.enable))
    else $error("enable bit read back wrong");

  rate_read_a: assert property (rd_pm
                                |=> o_rdata[`SCCPM_BIT_RATE] == $past(rate_changed_q))
    else $error("rate bit read back wrong");

  policy_read_a: assert property (rd_skt
                                  |=> o_rdata[`SCCPM_BIT_POLICY] == $past(ctl_q.stop_policy))
    else $error("policy bit read back wrong");

  // idle counter
  idle_clear_a: assert property (busy_s |=> idle_cnt_q == '0)
    else $error("idle count kept while busy");

  idle_step_a: assert property (!busy_s && card_edge && idle_cnt_q != IDLE_MAX
                                |=> idle_cnt_q == $past(idle_cnt_q) + CW'(1))
    else $error("idle count missed a card clock edge");

  idle_hold_a: assert property (!busy_s && !card_edge |=> $stable(idle_cnt_q))
    else $error("idle count moved without a card clock edge");

  idle_cap_a: assert property (idle_cnt_q <= IDLE_MAX)
    else $error("idle count beyond its limit");

  // state machine and request outputs
  state_onehot_a: assert property ($onehot(state_q))
    else $error("clock state not one-hot");

  run_stays_a: assert property (state_q == SCCPM_RUN && !may_attempt
                                |=> state_q == SCCPM_RUN)
    else $error("attempt without permission");

  stop_stays_a: assert property (state_q == SCCPM_STOP && !busy_s && ctl_q.enable
                                 |=> state_q == SCCPM_STOP)
    else $error("stop left while idle and enabled");

  slow_stays_a: assert property (state_q == SCCPM_SLOW && !busy_s && ctl_q.enable
                                 |=> state_q == SCCPM_SLOW)
    else $error("slow left while idle and enabled");

  no_jump_a: assert property (state_q == SCCPM_STOP |=> state_q != SCCPM_SLOW)
    else $error("stop handed over to slow directly");

  one_req_a: assert property (!(o_clk_stop_req && o_clk_slow_req))
    else $error("stop and slow requested together");

  stop_state_a: assert property (o_clk_stop_req == (state_q == SCCPM_STOP))
    else $error("stop request disagrees with state");

  slow_state_a: assert property (o_clk_slow_req == (state_q == SCCPM_SLOW))
    else $error("slow request disagrees with state");

  rate_enter_a: assert property (enter_evt |=> rate_changed_q)
    else $error("rate bit not set on stop or slow");

  rate_idle_a: assert property (state_q == SCCPM_RUN |-> !rate_changed_q)
    else $error("rate bit set at full rate");

  // interrupt status, enable and output
  irq_access_a: assert property (access_evt |=> irq_stat_q[`SCCPM_IRQ_ACCESS])
    else $error("access status bit not set");

  irq_enter_a: assert property (enter_evt |=> irq_stat_q[`SCCPM_IRQ_CHANGE])
    else $error("change status bit not set");

  irq_restore_a: assert property (leave_evt |=> irq_stat_q[`SCCPM_IRQ_RESTORE])
    else $error("restore status bit not set");

  irq_clear_a: assert property (wr_clr && bus.wdata[`SCCPM_IRQ_ACCESS] && !access_evt
                                |=> !irq_stat_q[`SCCPM_IRQ_ACCESS])
    else $error("access status bit not cleared");

  irq_sticky_a: assert property (irq_stat_q[`SCCPM_IRQ_RESTORE] && !wr_clr
                                 |=> irq_stat_q[`SCCPM_IRQ_RESTORE])
    else $error("restore status bit dropped without a clear");

  irq_enable_a: assert property (wr_en |=> irq_en_q == $past(bus.wdata[2:0]))
    else $error("interrupt enable not written");

  irq_level_a: assert property (o_irq == |(irq_stat_q & irq_en_q))
    else $error("interrupt level disagrees with status");

  // read port idles at zero, unmapped reads return zero
  rdata_zero_a: assert property (!bus.rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  unmapped_zero_a: assert property (bus.rd && !rd_mapped |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  stop_seen_c: cover property (enter_evt && !ctl_q.slow_sel);
  slow_seen_c: cover property (enter_evt && ctl_q.slow_sel);
  clear_race_c: cover property (rd_pm && access_evt);
  wake_seen_c: cover property (leave_evt && busy_s);
  host_gate_c: cover property (enter_evt && !ctl_q.stop_policy);

endmodule : sccpm_idle_clock_ctl

// ==== dv/sccpm_card_model.sv ====
// card side of the socket: card clock pin and socket busy level.
// assumes the bench says when the clock runs and when the card is in use.
`timescale 1ns/10ps
module sccpm_card_model (
  input wire logic i_run, // let the card clock toggle
  input wire logic i_busy, // card in active use
  output logic o_card_clk, // card clock, 200 ns period
  output logic o_card_busy // socket busy level
);
  // clock parks low outside active spans, so no stray edges feed the idle count
  initial begin
    o_card_clk = 1'b0;
    forever begin
      #100;
      o_card_clk = i_run ? ~o_card_clk : 1'b0;
    end
  end
  assign o_card_busy = i_busy;
endmodule : sccpm_card_model

// ==== dv/test_socket_card_clock_power_mgmt.sv ====
// self-checking bench for the idle card clock control registers and requests.
// assumes the card model drives the card pins; the bench is the register master.
`timescale 1ns/10ps
module test_socket_card_clock_power_mgmt;
  logic clk, rst, wr, rd, host, run, busy, cclk, cbusy, stp, slw, irq;
  logic [7:0] addr;
  logic [31:0] wd, rdat;
  int num_errors, checks_done, n;
  sccpm_idle_clock_ctl uut (.i_sys_clk(clk), .i_reset(rst), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_card_clk(cclk),
    .i_card_busy(cbusy), .i_host_stop_req(host), .o_clk_stop_req(stp),
    .o_clk_slow_req(slw), .o_irq(irq));
  sccpm_card_model card (.i_run(run), .i_busy(busy), .o_card_clk(cclk),
    .o_card_busy(cbusy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdat, exp);
  endtask : rd_reg
  // bounded wait for either request; n keeps the cycles spent
  task automatic wait_req;
    n = 0;
    @(negedge clk);
    while ((stp | slw) !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_req
  task automatic idle_chk(input int cyc);
    repeat (cyc) @(posedge clk);
    @(negedge clk);
    chk({30'h0, stp, slw}, 32'h0);
  endtask : idle_chk
  task automatic print_verdict;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    num_errors++;
    print_verdict();
  end
  initial begin
    num_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wd = 32'h0;
    host = 1'b0;
    run = 1'b0;
    busy = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h20, 32'h0000_0000);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    rd_reg(8'h20, 32'h0001_0001);
    rd_reg(8'h44, 32'h0000_0000);
    wr_reg(8'h2C, 32'h0000_0007);
    wr_reg(8'h10, 32'h0000_0080);
    wr_reg(8'h20, 32'h0001_0000);
    run <= 1'b1;
    wait_req();
    chk({31'h0, n >= 56}, 32'h1);
    chk({30'h0, stp, slw}, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rd_reg(8'h20, 32'h0101_0000);
    rd_reg(8'h24, 32'h0000_0002);
    @(posedge clk);
    busy <= 1'b1;
    idle_chk(120);
    rd_reg(8'h20, 32'h0201_0000);
    rd_reg(8'h20, 32'h0001_0000);
    rd_reg(8'h24, 32'h0000_0007);
    wr_reg(8'h28, 32'h0000_0007);
    rd_reg(8'h24, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    // only the access event stays unmasked now
    wr_reg(8'h2C, 32'h0000_0001);
    wr_reg(8'h20, 32'h0001_0001);
    busy <= 1'b0;
    wait_req();
    chk({30'h0, stp, slw}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr_reg(8'h10, 32'h0000_0000);
    busy <= 1'b1;
    repeat (8) @(posedge clk);
    busy <= 1'b0;
    idle_chk(150);
    @(posedge clk);
    host <= 1'b1;
    wait_req();
    chk({30'h0, stp, slw}, 32'h1);
    wr_reg(8'h20, 32'h0000_0001);
    idle_chk(150);
    rd_reg(8'h20, 32'h0200_0001);
    print_verdict();
  end
endmodule : test_socket_card_clock_power_mgmt
